/* hdl/hsa_pkg.sv */
// Package: register map, field positions, reset values and timing
package hsa_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ALARM_CTRL_OFS = 8'h1c;
    localparam logic [7:0] CONV_CTRL_OFS  = 8'h1d;
    localparam logic [7:0] FLAGS1_OFS     = 8'h1e;
    localparam logic [7:0] FLAGS2_OFS     = 8'h1f;
    localparam logic [7:0] NV_CTRL1_OFS   = 8'h20;
    localparam logic [7:0] NV_CTRL2_OFS   = 8'h21;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int ALARM_RAISED_BIT = 7;
    localparam int ALARM_FORCE_BIT  = 6;
    localparam int REBOOT_BIT       = 7;
    localparam int METER_CLR_BIT    = 6;
    localparam int METER_FRZ_BIT    = 5;
    localparam int FLOG_EN_BIT      = 2;
    localparam int CONV_STOP_BIT    = 0;
    localparam int NV_FMASK_BIT     = 7;
    localparam int NV_ONPIN_BIT     = 3;

    // ****************************************
    // Reset values and widths
    // ****************************************
    localparam logic [7:0] NV_CTRL1_RST  = 8'hbb;
    localparam logic [7:0] NV_CTRL2_RST  = 8'h02;
    localparam logic [7:0] SAVED_LOG_RST = 8'h00;
    localparam int ENERGY_W = 48;
    localparam int CYCLE_W  = 32;
    localparam int SAMPLE_W = 16;
    localparam int CNT_W    = 28;

    // ****************************************
    // Timing
    // ****************************************
    localparam real CLK_HZ        = 50.0e6;
    localparam real REBOOT_TIME_S = 3.2;
    localparam int unsigned REBOOT_CYCLES_DFLT =
        int'($ceil(REBOOT_TIME_S * CLK_HZ));
    localparam int unsigned NV_WRITE_CYCLES_DFLT = 2000;

    // Reboot sequencer states
    typedef enum logic [1:0]
    {
        BOOT_RUN   = 2'b00,
        BOOT_OFF   = 2'b01,
        BOOT_START = 2'b11
    } hsa_boot_t;
endpackage

/* hdl/hsa_link_if.sv */
// Interface: meter and nonvolatile write signals between modules
`timescale 1ns/1ps
interface hsa_link_if
    import hsa_pkg::*;
();
    logic                meterClear;
    logic                meterFreeze;
    logic                convDone;
    logic [SAMPLE_W-1:0] sample;
    logic [ENERGY_W-1:0] energy;
    logic [CYCLE_W-1:0]  cycles;
    logic                accWrap;
    logic                cycWrap;
    logic                nvReq;
    logic                nvReqLog;
    logic [7:0]          faultLog;
    logic [7:0]          alertLog;
    logic                nvBusy;
    logic [7:0]          savedFault;
    logic [7:0]          savedAlert;

    modport ctrl (output meterClear, meterFreeze, convDone, sample,
                  nvReq, nvReqLog, faultLog, alertLog,
                  input energy, cycles, accWrap, cycWrap,
                  nvBusy, savedFault, savedAlert);
    modport meter (input meterClear, meterFreeze, convDone, sample,
                   output energy, cycles, accWrap, cycWrap);
    modport nvm (input nvReq, nvReqLog, faultLog, alertLog,
                 output nvBusy, savedFault, savedAlert);
endinterface

/* hdl/hsa_meter.sv */
// Energy accumulator and conversion cycle counter
`timescale 1ns/1ps
module hsa_meter
    import hsa_pkg::*;
(
    // Clock and reset
    input logic          ref_clk,
    input logic          reset_n,
    // Meter controls and results
    hsa_link_if.meter    link
);
    logic [ENERGY_W:0] eSum;
    logic [CYCLE_W:0]  cSum;

    // Sums with carry out for the wrap flags
    assign eSum = {1'b0, link.energy} + (ENERGY_W+1)'(link.sample);
    assign cSum = {1'b0, link.cycles} + (CYCLE_W+1)'(1);

    // Accumulate one sample per finished conversion
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || link.meterClear)
        begin
            link.energy  <= '0;
            link.cycles  <= '0;
            link.accWrap <= 1'b0;
            link.cycWrap <= 1'b0;
        end
        else if (link.convDone && !link.meterFreeze)
        begin
            link.energy  <= eSum[ENERGY_W-1:0];
            link.cycles  <= cSum[CYCLE_W-1:0];
            link.accWrap <= link.accWrap | eSum[ENERGY_W];
            link.cycWrap <= link.cycWrap | cSum[CYCLE_W];
        end
    end
endmodule

/* hdl/hsa_nvm.sv */
// Nonvolatile write engine with busy timing and saved logs
`timescale 1ns/1ps
module hsa_nvm
    import hsa_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
)
(
    // Clock and reset
    input logic          ref_clk,
    input logic          reset_n,
    // Write requests and results
    hsa_link_if.nvm      link
);
    logic             pend_q;
    logic             pendLog_q;
    logic             launch;
    logic [CNT_W-1:0] cnt_q;

    // A waiting request starts once the memory is free
    assign launch = pend_q && !link.nvBusy;

    // Pending requests, a new one wins over the launch clear
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pend_q    <= 1'b0;
            pendLog_q <= 1'b0;
        end
        else
        begin
            pend_q    <= link.nvReq || (pend_q && !launch);
            pendLog_q <= link.nvReqLog || (pendLog_q && !launch);
        end
    end

    // Busy for the whole write time
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            link.nvBusy <= 1'b0;
            cnt_q       <= '0;
        end
        else if (launch)
        begin
            link.nvBusy <= 1'b1;
            cnt_q       <= CNT_W'(WRITE_CYCLES - 1);
        end
        else if (link.nvBusy)
        begin
            if (cnt_q == '0)
                link.nvBusy <= 1'b0;
            else
                cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    // Log copies taken when a log write starts
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            link.savedFault <= SAVED_LOG_RST;
            link.savedAlert <= SAVED_LOG_RST;
        end
        else if (launch && pendLog_q)
        begin
            link.savedFault <= link.faultLog;
            link.savedAlert <= link.alertLog;
        end
    end
endmodule

/* hdl/hsa_status_regs.sv */
// Alarm, converter control, status and boot default registers
`timescale 1ns/1ps
// Notes on behaviour
// - Any alert sets the alarm-raised flag
// - Flag stays until host writes zero
// - Host writing one sets the flag
// - Force-low bit pulls the alarm pin low
// - Reboot bit: off, reload defaults, restart later if the on-pin bit is set
// - Meter clear zeroes and holds both counters
// - Meter freeze stops both counters
// - Enabled fault rise saves both logs nonvolatile
// - Drive-low flag reads gate not above 8V
// - Rewriting stop bit runs one conversion
// - Status byte one reports switch and input state
// - Status byte two reports pin levels
// - Busy flag high during every nonvolatile write
// - Idle flag only when stopped in single-shot
// - Wrap flags report counter overflows
// - Fault mask default, restores saved fault log
// - Boot on-state default, shipped one
// - Boot retry default, shipped 011
// - Boot control byte one default bits 011
// - Boot control byte two default 0x02
// - Cycle counter counts accumulated conversions
module hsa_status_regs
    import hsa_pkg::*;
#(
    parameter int unsigned REBOOT_CYCLES   = REBOOT_CYCLES_DFLT,
    parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
)
(
    // Clock and reset
    input  logic                ref_clk,
    input  logic                reset_n,
    // Register port
    input  logic [7:0]          regAddr,
    input  logic [7:0]          regWrData,
    input  logic                regWrEn,
    input  logic                regRdEn,
    output logic [7:0]          regRdData,
    // Alarm pin, open drain
    input  logic                alarmPinLevel,
    output logic                alarmPinOut,
    output logic                alarmPinOe,
    // Alert events and logs
    input  logic                alertEvent,
    input  logic [7:0]          faultLog,
    input  logic [7:0]          convAlertLog,
    output logic                alarmRaised,
    // Switch and supply state
    input  logic                switchOnCmd,
    input  logic                switchFaultCooling,
    input  logic                switchShortDetected,
    input  logic                onPinLevel,
    input  logic                outputPowerGood,
    input  logic                overcurrentCooling,
    input  logic                inputUnderThreshold,
    input  logic                inputOverThreshold,
    input  logic                gateAboveDrive,
    input  logic                auxPin3Level,
    input  logic                auxPin2Level,
    input  logic                auxPin1Level,
    // Converter
    input  logic                convDone,
    input  logic [SAMPLE_W-1:0] powerSample,
    output logic                convRun,
    output logic                convTrigger,
    // Reboot and boot defaults
    output logic                switchOff,
    output logic                restartReq,
    output logic                bootLoad,
    output logic [7:0]          bootDefault1,
    output logic [7:0]          bootDefault2,
    output logic                faultLogRestore,
    output logic [7:0]          restoreValue,
    output logic [7:0]          savedAlertLog,
    // Meter values
    output logic [ENERGY_W-1:0] energyValue,
    output logic [CYCLE_W-1:0]  cycleCount
);
    // ****************************************
    // Declarations
    // ****************************************
    hsa_link_if link ();

    logic             wrAlarm;
    logic             wrConv;
    logic             wrNv;
    logic             rebootStart;
    logic             shotTrigger;
    logic             logSave;
    logic             convIdle;
    logic             switchDriveLowFlag;
    logic             alarmRaised_q;
    logic             alarmForce_q;
    logic             alarmPinOut_q;
    logic             meterClr_q;
    logic             meterFrz_q;
    logic             faultLogEn_q;
    logic             convStop_q;
    logic             shotPend_q;
    logic             convRun_q;
    logic             convTrigger_q;
    logic [7:0]       faultPrev_q;
    logic [7:0]       nvCtrl1_q;
    logic [7:0]       nvCtrl2_q;
    hsa_boot_t        bootState_q;
    hsa_boot_t        bootState_d;
    logic [CNT_W-1:0] bootCnt_q;
    logic             switchOff_q;
    logic             restartReq_q;
    logic             bootLoad_q;
    logic [7:0]       bootDefault1_q;
    logic [7:0]       bootDefault2_q;
    logic             faultLogRestore_q;
    logic [7:0]       restoreValue_q;
    logic [7:0]       rdMux;
    logic [7:0]       regRdData_q;

    // ****************************************
    // Register port decode
    // ****************************************
    // Status bytes have no write strobe at all
    assign wrAlarm = regWrEn && (regAddr == ALARM_CTRL_OFS);
    assign wrConv  = regWrEn && (regAddr == CONV_CTRL_OFS);
    assign wrNv    = regWrEn && !link.nvBusy
                     && ((regAddr == NV_CTRL1_OFS)
                     || (regAddr == NV_CTRL2_OFS));

    // Reboot only starts from normal running
    assign rebootStart = wrConv && regWrData[REBOOT_BIT]
                         && (bootState_q == BOOT_RUN);
    // Another stop-bit write while stopped asks for one conversion
    assign shotTrigger = wrConv && !rebootStart
                         && regWrData[CONV_STOP_BIT] && convStop_q;
    // Any fault bit going high while logging is on
    assign logSave = faultLogEn_q && |(faultLog & ~faultPrev_q);
    // Gate drive low unless above the drive level
    assign switchDriveLowFlag = !gateAboveDrive;
    // Idle only when stopped and no single conversion waits
    assign convIdle = convStop_q && !shotPend_q;

    // ****************************************
    // Alarm control
    // ****************************************
    // Raised flag: an alert wins over a clearing write
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            alarmRaised_q <= 1'b0;
        else if (alertEvent)
            alarmRaised_q <= 1'b1;
        else if (wrAlarm)
            alarmRaised_q <= regWrData[ALARM_RAISED_BIT];
    end

    // Pin pull-down; reloaded to off by a reboot
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || rebootStart)
            alarmForce_q <= 1'b0;
        else if (wrAlarm)
            alarmForce_q <= regWrData[ALARM_FORCE_BIT];
    end

    // Driven level of the open-drain pin is always low
    always_ff @(posedge ref_clk)
    begin
        alarmPinOut_q <= 1'b0;
    end

    // ****************************************
    // Converter and meter control
    // ****************************************
    // Writable fields; a reboot reloads their defaults
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || rebootStart)
        begin
            meterClr_q   <= 1'b0;
            meterFrz_q   <= 1'b0;
            faultLogEn_q <= 1'b0;
            convStop_q   <= 1'b0;
        end
        else if (wrConv)
        begin
            meterClr_q   <= regWrData[METER_CLR_BIT];
            meterFrz_q   <= regWrData[METER_FRZ_BIT];
            faultLogEn_q <= regWrData[FLOG_EN_BIT];
            convStop_q   <= regWrData[CONV_STOP_BIT];
        end
    end

    // Single conversion pending; a new trigger wins over done
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || !convStop_q)
            shotPend_q <= 1'b0;
        else if (shotTrigger)
            shotPend_q <= 1'b1;
        else if (convDone)
            shotPend_q <= 1'b0;
    end

    // Converter run level and single conversion pulse
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            convRun_q     <= 1'b0;
            convTrigger_q <= 1'b0;
        end
        else
        begin
            convRun_q     <= !convStop_q || shotPend_q;
            convTrigger_q <= shotTrigger;
        end
    end

    // ****************************************
    // Fault logging and nonvolatile control
    // ****************************************
    // Previous fault bits for rise detection
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            faultPrev_q <= 8'h00;
        else
            faultPrev_q <= faultLog;
    end

    // Boot default bytes; writes refused while memory busy
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            nvCtrl1_q <= NV_CTRL1_RST;
            nvCtrl2_q <= NV_CTRL2_RST;
        end
        else if (wrNv && (regAddr == NV_CTRL1_OFS))
            nvCtrl1_q <= regWrData;
        else if (wrNv)
            nvCtrl2_q <= regWrData;
    end

    // Requests to the nonvolatile write engine
    assign link.nvReq    = wrNv || logSave;
    assign link.nvReqLog = logSave;
    assign link.faultLog = faultLog;
    assign link.alertLog = convAlertLog;

    hsa_nvm #(
        .WRITE_CYCLES (NV_WRITE_CYCLES)
    ) nvmInst (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .link    (link.nvm)
    );

    // ****************************************
    // Energy meter
    // ****************************************
    assign link.meterClear  = meterClr_q;
    assign link.meterFreeze = meterFrz_q;
    assign link.convDone    = convDone;
    assign link.sample      = powerSample;

    hsa_meter meterInst (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .link    (link.meter)
    );

    // ****************************************
    // Reboot sequencer
    // ****************************************
    // Run, switched off for the delay, then one boot cycle
    always_comb
    begin
        bootState_d = bootState_q;
        unique case (bootState_q)
            BOOT_RUN:
                if (rebootStart)
                    bootState_d = BOOT_OFF;
            BOOT_OFF:
                if (bootCnt_q == '0)
                    bootState_d = BOOT_START;
            BOOT_START:
                bootState_d = BOOT_RUN;
            default:
                bootState_d = BOOT_START;
        endcase
    end

    // Power-up runs the boot cycle too
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            bootState_q <= BOOT_START;
        else
            bootState_q <= bootState_d;
    end

    // Off-time counter
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            bootCnt_q <= '0;
        else if (rebootStart)
            bootCnt_q <= CNT_W'(REBOOT_CYCLES - 1);
        else if (bootCnt_q != '0)
            bootCnt_q <= bootCnt_q - CNT_W'(1);
    end

    // Boot outputs, restart only when on-pin mode is chosen
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            switchOff_q       <= 1'b0;
            restartReq_q      <= 1'b0;
            bootLoad_q        <= 1'b0;
            faultLogRestore_q <= 1'b0;
            restoreValue_q    <= 8'h00;
        end
        else
        begin
            switchOff_q  <= (bootState_d == BOOT_OFF);
            restartReq_q <= (bootState_q == BOOT_START)
                            && nvCtrl1_q[NV_ONPIN_BIT];
            bootLoad_q   <= (bootState_q == BOOT_START);
            faultLogRestore_q <= (bootState_q == BOOT_START)
                                 && nvCtrl1_q[NV_FMASK_BIT];
            restoreValue_q <= link.savedFault;
        end
    end

    // Boot default copies for the live control bytes
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            bootDefault1_q <= NV_CTRL1_RST;
            bootDefault2_q <= NV_CTRL2_RST;
        end
        else
        begin
            bootDefault1_q <= nvCtrl1_q;
            bootDefault2_q <= nvCtrl2_q;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Read mux; reserved bits and unmapped offsets read zero
    always_comb
    begin
        rdMux = 8'h00;
        unique case (regAddr)
            ALARM_CTRL_OFS:
                rdMux = {alarmRaised_q, alarmForce_q, 6'h00};
            CONV_CTRL_OFS:
                rdMux = {bootState_q == BOOT_OFF, meterClr_q, meterFrz_q,
                         2'b00, faultLogEn_q, switchDriveLowFlag,
                         convStop_q};
            FLAGS1_OFS:
                rdMux = {switchOnCmd, switchFaultCooling,
                         switchShortDetected, onPinLevel,
                         outputPowerGood, overcurrentCooling,
                         inputUnderThreshold,
                         inputOverThreshold};
            FLAGS2_OFS:
                rdMux = {auxPin3Level, auxPin2Level, auxPin1Level,
                         alarmPinLevel, link.nvBusy, convIdle,
                         link.cycWrap, link.accWrap};
            NV_CTRL1_OFS:
                rdMux = nvCtrl1_q;
            NV_CTRL2_OFS:
                rdMux = nvCtrl2_q;
            default:
                rdMux = 8'h00;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            regRdData_q <= 8'h00;
        else if (regRdEn)
            regRdData_q <= rdMux;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign regRdData       = regRdData_q;
    assign alarmPinOut     = alarmPinOut_q;
    assign alarmPinOe      = alarmForce_q;
    assign alarmRaised     = alarmRaised_q;
    assign convRun         = convRun_q;
    assign convTrigger     = convTrigger_q;
    assign switchOff       = switchOff_q;
    assign restartReq      = restartReq_q;
    assign bootLoad        = bootLoad_q;
    assign bootDefault1    = bootDefault1_q;
    assign bootDefault2    = bootDefault2_q;
    assign faultLogRestore = faultLogRestore_q;
    assign restoreValue    = restoreValue_q;
    assign savedAlertLog   = link.savedAlert;
    assign energyValue     = link.energy;
    assign cycleCount      = link.cycles;
endmodule

/* tb/hsa_status_regs_chk.sv */
// Checker: alarm, pin, meter and reboot timing
`timescale 1ns/1ps
module hsa_status_regs_chk
    import hsa_pkg::*;
(
    // Clock, reset and watched ports
    input wire logic ref_clk, reset_n, regWrEn, regRdEn, alertEvent,
    input wire logic alarmRaised, alarmPinOut, alarmPinOe, gateAboveDrive,
    input wire logic switchOff,
    input wire logic [7:0] regAddr, regWrData, regRdData,
    input wire logic [CYCLE_W-1:0] cycleCount
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Host writes to the converter control byte
    sequence clrWr; regWrEn && regAddr == 8'h1d && regWrData[6]; endsequence
    sequence frzWr; regWrEn && regAddr == 8'h1d && regWrData[5]; endsequence
    sequence rbWr; regWrEn && regAddr == 8'h1d && regWrData[7]; endsequence
    alarm_set_a: assert property (
        alertEvent |=> alarmRaised) else $error("alarm flag not set");
    alarm_keep_a: assert property (
        alarmRaised && !(regWrEn && regAddr == 8'h1c && !regWrData[7])
        |=> alarmRaised) else $error("alarm flag lost");
    alarm_sim_a: assert property (
        regWrEn && regAddr == 8'h1c && regWrData[7] |=> alarmRaised)
        else $error("alarm write ignored");
    pin_force_a: assert property (
        regWrEn && regAddr == 8'h1c && !switchOff
        |=> alarmPinOe == $past(regWrData[6])) else $error("pin enable");
    pin_level_a: assert property (
        alarmPinOe |-> !alarmPinOut) else $error("pin not low");
    gate_flag_a: assert property (
        regRdEn && regAddr == 8'h1d |=> regRdData[4:3] == 2'b00
        && regRdData[1] != $past(gateAboveDrive)) else $error("gate flag");
    meter_clear_a: assert property (
        clrWr |=> ##1 cycleCount == '0) else $error("count not cleared");
    meter_hold_a: assert property (
        frzWr |=> ##1 $stable(cycleCount)[*4]) else $error("count moved");
    reboot_off_a: assert property (
        rbWr |=> switchOff[*8]) else $error("switch not off");
endmodule
bind hsa_status_regs hsa_status_regs_chk i_chk (.ref_clk, .reset_n,
    .regWrEn, .regRdEn, .alertEvent, .alarmRaised, .alarmPinOut,
    .alarmPinOe, .gateAboveDrive, .switchOff, .regAddr, .regWrData,
    .regRdData, .cycleCount);

/* tb/hsa_host.sv */
// Host model: byte reads and writes on the register port
`timescale 1ns/1ps
module hsa_host
(
    // Clock and register port
    input  wire logic ref_clk,
    input  wire logic [7:0] regRdData,
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWrData = 8'h00,
    output logic regWrEn = 1'b0,
    output logic regRdEn = 1'b0
);
    // One write over one taking edge
    task automatic wr(input logic [7:0] a, d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask
    // One read, data taken after the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge ref_clk);
        regRdEn = 1'b0;
        d = regRdData;
    endtask
endmodule

/* tb/test_hsa_status_regs.sv */
// Testbench: hot-swap status register block
`timescale 1ns/1ps
module test_hsa_status_regs import hsa_pkg::*;;
    logic ref_clk = 0, reset_n = 0, alertEvent = 0, convDone = 0;
    logic gateAboveDrive = 1, alarmRaised, alarmPinOut, alarmPinOe, convRun;
    logic convTrigger, switchOff, restartReq, bootLoad, faultLogRestore;
    logic regWrEn, regRdEn;
    logic [7:0] regAddr, regWrData, regRdData, faultLog = 0, st1 = 0;
    logic [7:0] bd1, bd2, rsv, sal;
    logic [3:0] pins = 0;
    logic [15:0] powerSample = 16'h0003;
    logic [47:0] energyValue;
    logic [31:0] cycleCount;
    int nFail = 0, checksDone = 0, cyc = 0;
    // Alarm wire, pulled low by the block
    wire alarmPinLevel = pins[0] & ~alarmPinOe;
    hsa_status_regs #(.REBOOT_CYCLES(20), .NV_WRITE_CYCLES(8))
        i_hsa_status_regs (.ref_clk, .reset_n, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .regRdData, .alarmPinLevel, .alarmPinOut,
        .alarmPinOe, .alertEvent, .faultLog, .convAlertLog(st1),
        .alarmRaised, .switchOnCmd(st1[7]), .switchFaultCooling(st1[6]),
        .switchShortDetected(st1[5]), .onPinLevel(st1[4]),
        .outputPowerGood(st1[3]), .overcurrentCooling(st1[2]),
        .inputUnderThreshold(st1[1]), .inputOverThreshold(st1[0]),
        .gateAboveDrive, .auxPin3Level(pins[3]), .auxPin2Level(pins[2]),
        .auxPin1Level(pins[1]), .convDone, .powerSample, .convRun,
        .convTrigger, .switchOff, .restartReq, .bootLoad, .bootDefault1(bd1),
        .bootDefault2(bd2), .faultLogRestore, .restoreValue(rsv),
        .savedAlertLog(sal), .energyValue, .cycleCount);
    hsa_host i_hsa_host (.ref_clk, .regRdData, .regAddr, .regWrData,
        .regWrEn, .regRdEn);
    // Clock and hang guard
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            nFail++;
            wrapUp;
        end
    end
    task automatic wrapUp;
        $display("checks %0d failures %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Masked read and compare
    task automatic rdc(input logic [7:0] a, m, e);
        logic [7:0] d;
        i_hsa_host.rd(a, d);
        chk(d & m, e);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1;
        @(negedge ref_clk) s = 0;
    endtask
    // Alarm flag and pin
    task automatic tAlarm;
        pulse(alertEvent);
        rdc(8'h1c, 8'hff, 8'h80);
        i_hsa_host.wr(8'h1c, 8'h00);
        rdc(8'h1c, 8'hff, 8'h00);
        i_hsa_host.wr(8'h1c, 8'hff);
        rdc(8'h1c, 8'hff, 8'hc0);
        chk({7'h0, alarmPinOe}, 8'h01);
        i_hsa_host.wr(8'h1c, 8'h00);
    endtask
    // Status bytes, writes refused
    task automatic tStatus;
        st1 = 8'ha5;
        pins = 4'b1011;
        rdc(8'h1e, 8'hff, 8'ha5);
        i_hsa_host.wr(8'h1e, 8'h00);
        rdc(8'h1e, 8'hff, 8'ha5);
        rdc(8'h1f, 8'hf0, 8'hb0);
        gateAboveDrive = 0;
        rdc(8'h1d, 8'h02, 8'h02);
    endtask
    // Boot defaults, logged fault write
    task automatic tNv;
        rdc(8'h20, 8'hff, 8'hbb);
        rdc(8'h21, 8'hff, 8'h02);
        i_hsa_host.wr(8'h1d, 8'h04);
        faultLog = 8'h01;
        wait_n(3);
        rdc(8'h1f, 8'h08, 8'h08);
        wait_n(10);
        rdc(8'h1f, 8'h08, 8'h00);
    endtask
    // Single-shot conversions
    task automatic tShot;
        i_hsa_host.wr(8'h1d, 8'h01);
        pulse(convDone);
        rdc(8'h1f, 8'h07, 8'h04);
        i_hsa_host.wr(8'h1d, 8'h01);
        chk({6'h0, convRun, convTrigger}, 8'h01);
        rdc(8'h1f, 8'h04, 8'h00);
        pulse(convDone);
        wait_n(2);
        rdc(8'h1f, 8'h04, 8'h04);
        i_hsa_host.wr(8'h1d, 8'h00);
        wait_n(3);
        rdc(8'h1f, 8'h04, 8'h00);
    endtask
    // Clear, count, freeze
    task automatic tMeter;
        i_hsa_host.wr(8'h1d, 8'h40);
        pulse(convDone);
        chk(cycleCount[7:0], 8'h00);
        i_hsa_host.wr(8'h1d, 8'h00);
        pulse(convDone);
        pulse(convDone);
        chk(energyValue[7:0], 8'h06);
        i_hsa_host.wr(8'h1d, 8'h20);
        pulse(convDone);
        wait_n(4);
        chk(cycleCount[7:0], 8'h02);
        i_hsa_host.wr(8'h1d, 8'h00);
    endtask
    // Reboot and boot outputs
    task automatic tReboot;
        int i;
        i_hsa_host.wr(8'h1d, 8'h80);
        for (i = 0; i < 40 && bootLoad !== 1'b1; i++)
            @(negedge ref_clk);
        chk({5'h0, i == 21, restartReq, faultLogRestore}, 8'h07);
        chk(rsv, 8'h01);
        chk(sal, 8'ha5);
        chk(bd1, 8'hbb);
        chk(bd2, 8'h02);
    endtask
    initial
    begin
        wait_n(5);
        reset_n = 1;
        tAlarm;
        tStatus;
        tNv;
        tShot;
        tMeter;
        tReboot;
        wrapUp;
    end
endmodule
